// *** rtl/dpc_map.svh ***
// Register offsets, field positions, reset values and timing counts of the
// dual channel position capture block.
// Assumes a 10 MHz system clock and byte addressing on an APB port.
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

`define DPC_ADDR_W 8
`define DPC_OFF_TRIG_SRC 8'h00
`define DPC_OFF_POS_SRC 8'h04
`define DPC_OFF_POLARITY 8'h08
`define DPC_OFF_ARM 8'h0C
`define DPC_OFF_DONE 8'h10
`define DPC_OFF_ACT1 8'h14
`define DPC_OFF_ACT2 8'h18
`define DPC_OFF_REF1 8'h1C
`define DPC_OFF_REF2 8'h20

`define DPC_RST_TRIG_SRC 4'h4
`define DPC_RST_POS_SRC 1'h1
`define DPC_RST_POLARITY 2'h3
`define DPC_RST_REPEAT 1'h0

`define DPC_ARM_ABORT_BIT 14
`define DPC_ARM_REPEAT_BIT 15
`define DPC_SRC_W 2
`define DPC_SRC_INPUT_ONE 2'h0
`define DPC_SRC_INPUT_TWO 2'h1
`define DPC_SRC_REF_INDEX 2'h2
`define DPC_SRC_ACT_INDEX 2'h3
`define DPC_SRC_INDEX_BIT 1

`define DPC_CLK_HZ 10_000_000
`define DPC_DELAY_US 100
`define DPC_SCATTER_US 10
`define DPC_DELAY_CYC ((`DPC_DELAY_US * `DPC_CLK_HZ + 999_999) / 1_000_000)
`define DPC_DLY_W 10

`endif

// *** rtl/dpc_pkg.sv ***
// Types shared by the dual channel position capture block.
// Assumes the offsets and counts of dpc_map.svh.
package dpc_pkg;

    typedef enum logic [2:0] {
        dpc_idle,
        dpc_wait,
        dpc_delay,
        dpc_fix,
        dpc_held
    } dpc_state_t;

    typedef struct packed {
        logic repeat_en;
        logic pos_src;
        logic rise;
        logic [1:0] trig_src;
    } dpc_cfg_t;

    typedef struct packed {
        logic [31:0] act;
        logic [31:0] ref_pos;
    } dpc_cap_t;

endpackage

// *** rtl/dpc_chan.sv ***
// One capture channel: input delay, latching of both positions, done flag.
// Assumes edge pulses come from a synchronised trigger and that arm and
// abort are single-cycle pulses from the register file.
`timescale 1ns/1ns
`include "dpc_map.svh"

module dpc_chan (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Commands and latched settings
    input wire logic arm,
    input wire logic abort,
    input wire logic repeat_en,
    input wire logic pos_src,
    input wire logic trig_edge,
    // Live positions
    input wire logic [31:0] act_pos,
    input wire logic [31:0] ref_pos,
    // Results
    output dpc_pkg::dpc_cap_t cap,
    output logic done
);
    import dpc_pkg::*;

    localparam logic [`DPC_DLY_W-1:0] DLY_LAST = `DPC_DLY_W'(`DPC_DELAY_CYC - 1);

    dpc_state_t state_q;
    logic [`DPC_DLY_W-1:0] dly_q;
    dpc_cap_t cap_q;
    logic done_q;

    assign cap = cap_q;
    assign done = done_q;

    always_ff @(posedge clk_sys) begin
        if (rst || abort) begin
            state_q <= dpc_idle;
        end else if (arm) begin
            state_q <= dpc_wait;
        end else begin
            case (state_q)
                // Edges inside the delay window are dropped, not queued.
                dpc_wait: if (trig_edge) state_q <= dpc_delay;
                dpc_delay: if (dly_q == DLY_LAST) state_q <= dpc_fix;
                dpc_fix: state_q <= repeat_en ? dpc_wait : dpc_held;
                dpc_idle: state_q <= dpc_idle;
                dpc_held: state_q <= dpc_held;
                default: state_q <= dpc_idle;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state_q != dpc_delay) begin
            dly_q <= '0;
        end else begin
            dly_q <= dly_q + `DPC_DLY_W'(1);
        end
    end

    // The selected source is frozen at the end of the delay; the other value
    // follows one cycle later, which is what software sees as derived.
    always_ff @(posedge clk_sys) begin
        if (rst || (arm && !abort)) begin
            cap_q <= '0;
        end else if (state_q == dpc_delay && dly_q == DLY_LAST) begin
            if (pos_src) cap_q.ref_pos <= ref_pos;
            else cap_q.act <= act_pos;
        end else if (state_q == dpc_fix) begin
            if (pos_src) cap_q.act <= act_pos;
            else cap_q.ref_pos <= ref_pos;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || (arm && !abort)) begin
            done_q <= 1'b0;
        end else if (state_q == dpc_fix) begin
            done_q <= 1'b1;
        end
    end

endmodule // dpc_chan

// *** rtl/dpc_top.sv ***
// Top of the dual channel position capture block: APB register file,
// trigger synchronisers, source selection, edge detection, two channels.
// Assumes an APB master on clk_sys and position words valid every cycle.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ns
`include "dpc_map.svh"

module dpc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger sources and encoder module presence
    input wire logic trigger_input_one,
    input wire logic trigger_input_two,
    input wire logic ref_index,
    input wire logic act_index,
    input wire logic encoder_module_slot,
    // Live positions
    input wire logic [31:0] act_pos,
    input wire logic [31:0] ref_pos
);
    import dpc_pkg::*;

    localparam int NCH = 2;
    localparam int NSRC = 4;

    function automatic logic hit(
        input logic [`DPC_ADDR_W-1:0] addr,
        input logic [`DPC_ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction

    function automatic logic pick(
        input logic [NSRC-1:0] lvl,
        input logic [`DPC_SRC_W-1:0] src
    );
        pick = lvl[src];
    endfunction

    // APB handshake.
    logic acc;
    logic wr_en;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    assign acc = psel && penable;
    // A write lands only at the edge where pready is seen high.
    assign wr_en = acc && pready_q && pwrite;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // Settings held by software.
    logic [3:0] trig_src_q;
    logic pos_src_q;
    logic [1:0] polarity_q;
    logic repeat_q;

    // Channel side.
    logic [NCH-1:0] arm;
    logic [NCH-1:0] abort;
    logic [NCH-1:0] done;
    logic [NCH-1:0] trig_edge;
    dpc_cfg_t cfg_q [NCH];
    dpc_cap_t cap [NCH];

    // Trigger synchronisers.
    logic [NSRC-1:0] trig_raw;
    logic [NSRC-1:0] sync1_q;
    logic [NSRC-1:0] sync2_q;
    logic fitted_q;

    assign trig_raw = {act_index, ref_index, trigger_input_two, trigger_input_one};

    // Register writes.
    logic wr_arm;

    assign wr_arm = wr_en && hit(paddr, `DPC_OFF_ARM);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_src_q <= `DPC_RST_TRIG_SRC;
        end else if (wr_en && hit(paddr, `DPC_OFF_TRIG_SRC)) begin
            trig_src_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pos_src_q <= `DPC_RST_POS_SRC;
        end else if (wr_en && hit(paddr, `DPC_OFF_POS_SRC)) begin
            pos_src_q <= pwdata[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            polarity_q <= `DPC_RST_POLARITY;
        end else if (wr_en && hit(paddr, `DPC_OFF_POLARITY)) begin
            polarity_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            repeat_q <= `DPC_RST_REPEAT;
        end else if (wr_arm) begin
            repeat_q <= pwdata[`DPC_ARM_REPEAT_BIT];
        end
    end

    // Abort stops both channels and overrides arm bits in the same write.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            abort[c] = wr_arm && pwdata[`DPC_ARM_ABORT_BIT];
            arm[c] = wr_arm && pwdata[c] && !pwdata[`DPC_ARM_ABORT_BIT];
        end
    end

    // APB timing: one wait state, read data loaded in the first access cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc && !pready_q;
        end
    end

    logic mapped;
    logic read_only;

    always_comb begin
        mapped = hit(paddr, `DPC_OFF_TRIG_SRC) || hit(paddr, `DPC_OFF_POS_SRC)
            || hit(paddr, `DPC_OFF_POLARITY) || hit(paddr, `DPC_OFF_ARM)
            || hit(paddr, `DPC_OFF_DONE) || hit(paddr, `DPC_OFF_ACT1)
            || hit(paddr, `DPC_OFF_ACT2) || hit(paddr, `DPC_OFF_REF1)
            || hit(paddr, `DPC_OFF_REF2);
        read_only = hit(paddr, `DPC_OFF_DONE) || hit(paddr, `DPC_OFF_ACT1)
            || hit(paddr, `DPC_OFF_ACT2) || hit(paddr, `DPC_OFF_REF1)
            || hit(paddr, `DPC_OFF_REF2);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pslverr_q <= 1'b0;
        end else if (acc && !pready_q) begin
            pslverr_q <= !mapped || (pwrite && read_only);
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hit(paddr, `DPC_OFF_TRIG_SRC)) begin
            rd_mux = {28'h000_0000, trig_src_q};
        end else if (hit(paddr, `DPC_OFF_POS_SRC)) begin
            rd_mux = {31'h0000_0000, pos_src_q};
        end else if (hit(paddr, `DPC_OFF_POLARITY)) begin
            rd_mux = {30'h0000_0000, polarity_q};
        end else if (hit(paddr, `DPC_OFF_ARM)) begin
            rd_mux = {16'h0000, repeat_q, 15'h0000};
        end else if (hit(paddr, `DPC_OFF_DONE)) begin
            rd_mux = {30'h0000_0000, done};
        end else if (hit(paddr, `DPC_OFF_ACT1)) begin
            rd_mux = cap[0].act;
        end else if (hit(paddr, `DPC_OFF_ACT2)) begin
            rd_mux = cap[1].act;
        end else if (hit(paddr, `DPC_OFF_REF1)) begin
            rd_mux = cap[0].ref_pos;
        end else if (hit(paddr, `DPC_OFF_REF2)) begin
            rd_mux = cap[1].ref_pos;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= '0;
        end else if (acc && !pready_q && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // Synchronise every trigger source once, so both channels see the same
    // delayed copy and a shared input cannot fire one channel early.
    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync1_q[s] <= 1'b0;
                    sync2_q[s] <= 1'b0;
                end else begin
                    sync1_q[s] <= trig_raw[s];
                    sync2_q[s] <= sync1_q[s];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fitted_q <= 1'b0;
        end else begin
            fitted_q <= encoder_module_slot;
        end
    end

    // Per channel: settings latched at arm, source selection, edge detect.
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic prev_q;
            logic lvl;
            logic src_ok;
            logic [`DPC_SRC_W-1:0] new_src;

            assign new_src = trig_src_q[`DPC_SRC_W*c +: `DPC_SRC_W];
            assign lvl = pick(sync2_q, cfg_q[c].trig_src);
            // Index sources stay quiet without an encoder module.
            assign src_ok = !cfg_q[c].trig_src[`DPC_SRC_INDEX_BIT] || fitted_q;

            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    cfg_q[c] <= '{
                        repeat_en: `DPC_RST_REPEAT,
                        pos_src: `DPC_RST_POS_SRC,
                        rise: polarity_q[c],
                        trig_src: `DPC_SRC_INPUT_ONE
                    };
                end else if (arm[c]) begin
                    cfg_q[c].repeat_en <= pwdata[`DPC_ARM_REPEAT_BIT];
                    cfg_q[c].pos_src <= pos_src_q;
                    cfg_q[c].rise <= polarity_q[c];
                    cfg_q[c].trig_src <= new_src;
                end
            end

            // On arm the reference level follows the new source, so a source
            // switch is not mistaken for an edge.
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    prev_q <= 1'b0;
                end else if (arm[c]) begin
                    prev_q <= pick(sync2_q, new_src);
                end else begin
                    prev_q <= lvl;
                end
            end

            always_comb begin
                if (cfg_q[c].rise) begin
                    trig_edge[c] = src_ok && lvl && !prev_q;
                end else begin
                    trig_edge[c] = src_ok && !lvl && prev_q;
                end
            end

            dpc_chan u_chan (
                .clk_sys(clk_sys),
                .rst(rst),
                .arm(arm[c]),
                .abort(abort[c]),
                .repeat_en(cfg_q[c].repeat_en),
                .pos_src(cfg_q[c].pos_src),
                .trig_edge(trig_edge[c]),
                .act_pos(act_pos),
                .ref_pos(ref_pos),
                .cap(cap[c]),
                .done(done[c])
            );
        end
    endgenerate

endmodule // dpc_top

// *** dv/dpc_far.sv ***
// Far side model: trigger inputs, index pulses and both encoders.
// Assumes the bench sets wanted levels and positions; pins follow one edge later.
`timescale 1ns/1ns
module dpc_far (
    // Clock
    input wire logic clk_sys,
    // Wanted levels and positions
    input wire logic [3:0] lvl,
    input wire logic [31:0] av,
    input wire logic [31:0] rv,
    // Pins towards the block
    output logic trigger_input_one,
    output logic trigger_input_two,
    output logic ref_index,
    output logic act_index,
    output logic [31:0] act_pos,
    output logic [31:0] ref_pos
);
    // Registered so that no pin ever moves in the same step as the block samples it.
    always_ff @(posedge clk_sys) begin
        {act_index, ref_index, trigger_input_two, trigger_input_one} <= lvl;
        act_pos <= av;
        ref_pos <= rv;
    end
endmodule // dpc_far

// *** dv/dpc_top_checker.sv ***
// Port checker for the capture block's APB register side.
// Assumes a single clock domain and the synchronous reset of the top.
`timescale 1ns/1ns
`include "dpc_map.svh"
module dpc_top_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`DPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic rd_done;
    assign rd_done = psel && penable && pready && !pwrite;

    AST_READY_AFTER_ACCESS: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_READY_NEEDS_ACCESS: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error outside ready");
    AST_RO_WRITE_REFUSED: assert property (pready && pwrite && paddr >= 8'h10 |-> pslverr)
        else $error("write to status accepted");
    AST_MAPPED_READ_OK: assert property (rd_done && paddr <= 8'h20 && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("mapped read refused");
    AST_UNMAPPED_READ_ZERO: assert property (rd_done && paddr > 8'h20
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    AST_DONE_WIDTH: assert property (rd_done && paddr == 8'h10 |-> prdata[31:2] == 30'h0)
        else $error("done read has extra bits");
    AST_ARM_READBACK: assert property (rd_done && paddr == 8'h0C
        |-> prdata[14:0] == 15'h0 && prdata[31:16] == 16'h0)
        else $error("arm read shows command bits");
    AST_EDGE_WIDTH: assert property (rd_done && paddr == 8'h08 |-> prdata[31:2] == 30'h0)
        else $error("polarity read has extra bits");
endmodule // dpc_top_checker

bind dpc_top dpc_top_checker u_dpc_top_checker (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// *** dv/tb.sv ***
// Self-checking bench for the capture block.
// Assumes one APB wait state and a capture latency near 1003 cycles.
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slot = 1'b1;
    logic [3:0] lvl = 4'h0;
    logic [31:0] av = 32'hFFFF_FF00;
    logic [31:0] rv = 32'h1234;
    logic t1, t2, ri, ai;
    logic [31:0] ap, rp, q;
    logic e;
    int fails = 0;
    int checked = 0;

    always #50 clk_sys = ~clk_sys;

    dpc_far u_dpc_far (.clk_sys(clk_sys), .lvl(lvl), .av(av), .rv(rv), .trigger_input_one(t1),
        .trigger_input_two(t2), .ref_index(ri), .act_index(ai), .act_pos(ap), .ref_pos(rp));
    dpc_top u_dpc_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_input_one(t1), .trigger_input_two(t2), .ref_index(ri),
        .act_index(ai), .encoder_module_slot(slot), .act_pos(ap), .ref_pos(rp));

    task automatic wrap_up;
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        checked++;
        if (got !== x) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, x);
        end
    endtask

    // Ready is sampled at the rising edge; the request holds until that very edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                fails++;
                $display("unexpected at %0t: no ready", $time);
                wrap_up;
            end
            @(posedge clk_sys);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic wait_done(input int ch);
        int n;
        n = 0;
        repeat (950) @(posedge clk_sys);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, q[ch]}, 32'h0);
        while (q[ch] !== 1'b1 && n < 40) begin
            n++;
            apb(1'b0, 8'h10, 32'h0);
        end
        chk({31'h0, q[ch]}, 32'h1);
        if (q[ch] !== 1'b1) begin
            wrap_up;
        end
    endtask

    task automatic retrig(input int b);
        lvl[b] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        lvl[b] <= 1'b1;
        repeat (1100) @(posedge clk_sys);
        lvl[b] <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic cap(input int ch, input logic [1:0] s, input int b, input logic [31:0] arm);
        wr(8'h00, {28'h0, s, s});
        wr(8'h08, 32'h3);
        wr(8'h0C, arm);
        rd(8'h14 + 8'(4 * ch), 32'h0);
        lvl[b] <= 1'b1;
        wait_done(ch);
        rd(8'h14 + 8'(4 * ch), av);
        rd(8'h1C + 8'(4 * ch), rv);
        lvl[b] <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic t_regs;
        rd(8'h00, 32'h4);
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h3);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h00, 32'hF);
        rd(8'h00, 32'hF);
        apb(1'b1, 8'h10, 32'h3);
        chk({31'h0, e}, 32'h1);
        rd(8'h10, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_caps;
        for (int s = 0; s < 4; s++) begin
            cap(0, 2'(s), s, 32'h1);
        end
        rv <= 32'h8000_0001;
        cap(1, 2'h1, 1, 32'h2);
    endtask

    task automatic t_repeat;
        logic [31:0] old;
        cap(0, 2'h0, 0, 32'h1);
        old = av;
        av <= 32'h7777;
        retrig(0);
        rd(8'h14, old);
        cap(0, 2'h0, 0, 32'h8001);
        rd(8'h0C, 32'h8000);
        av <= 32'h5555;
        retrig(0);
        rd(8'h14, 32'h5555);
    endtask

    task automatic t_polarity;
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
        lvl[1] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(8'h0C, 32'h2);
        wr(8'h08, 32'h3);
        wr(8'h04, 32'h1);
        lvl[1] <= 1'b0;
        wait_done(1);
        rd(8'h18, av);
        rd(8'h20, rv);
    endtask

    task automatic t_others;
        slot <= 1'b0;
        wr(8'h00, 32'hA);
        wr(8'h0C, 32'h1);
        retrig(2);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, q[0]}, 32'h0);
        slot <= 1'b1;
        wr(8'h00, 32'h4);
        wr(8'h0C, 32'h1);
        lvl[0] <= 1'b1;
        repeat (100) @(posedge clk_sys);
        wr(8'h0C, 32'h4000);
        repeat (1100) @(posedge clk_sys);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, q[0]}, 32'h0);
        lvl[0] <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_caps;
        t_repeat;
        t_polarity;
        t_others;
        wrap_up;
    end
endmodule // tb
